// ===== dv/host_reader.sv
// Host adapter model that fetches identify words one at a time.
module host_reader
    import ident_cap_pkg::*;
(
    input wire logic clk,
    output logic wordReq,
    output logic [7:0] wordIdx,
    input wire logic [15:0] wordData,
    input wire logic wordValid
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // The adapter starts idle.
    initial
    begin
        wordReq = 1'b0;
        wordIdx = 8'h00;
    end

    // Requests one word, then takes the answer in the following cycle.
    task automatic fetch(input logic [7:0] idx, output logic [15:0] data,
                         output logic ok);
        @(posedge clk);
        wordReq <= 1'b1;
        wordIdx <= idx;
        @(posedge clk);
        wordReq <= 1'b0;
        wordIdx <= ~idx;  // A stale index would now point elsewhere.
        // The answer is taken at the edge that samples wordValid.
        @(posedge clk);
        ok = wordValid;
        data = wordData;
    endtask : fetch
endmodule : host_reader

// ===== dv/tb_ident_cap_words.sv
// Self-checking bench for the identify capability words block.
module tb_ident_cap_words
    import ident_cap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals, configuration shadow and counters.
    localparam logic [15:0] D0 = 16'h01E0;
    localparam logic [15:0] D1 = 16'h0096;
    localparam logic [15:0] D2 = 16'h0078;
    logic clk = 1'b0;
    logic reset_n, psel, penable, pwrite, pready, pslverr;
    logic wordReq, wordValid, cmdAccepted, cmdCompleted;
    logic dmaThrottle, queueFull;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, dt, pt;
    logic [7:0] wordIdx;
    logic [15:0] wordData, hostCycleNs;
    logic [5:0] outstanding;
    logic [12:0] cfg;
    logic [4:0] qd;
    int errors = 0;
    int comparisons = 0;

    // The clock toggles every half period of 2 ns.
    always #2 clk = ~clk;

    // ==========================================================
    // Design and host adapter.
    ident_cap_words #(.DMA0_NS(D0), .DMA1_NS(D1), .DMA2_NS(D2))
    ident_cap_words_inst
    (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wordReq(wordReq),
        .wordIdx(wordIdx), .wordData(wordData), .wordValid(wordValid),
        .hostCycleNs(hostCycleNs), .cmdAccepted(cmdAccepted),
        .cmdCompleted(cmdCompleted), .dmaThrottle(dmaThrottle),
        .outstanding(outstanding), .queueFull(queueFull)
    );

    host_reader host_reader_inst
    (
        .clk(clk), .wordReq(wordReq), .wordIdx(wordIdx),
        .wordData(wordData), .wordValid(wordValid)
    );

    // ==========================================================
    // Expected identify word for a configuration.
    function automatic logic [15:0] mx(input logic [15:0] a,
                                       input logic [15:0] b);
        mx = (a > b) ? a : b;
    endfunction : mx

    function automatic logic [15:0] expWord(input logic [7:0] w);
        logic [2:0] sup;
        logic [1:0] pio;
        logic [15:0] dmin, drec, pfc, pnf;
        logic [4:0] idx;
        logic sel;
        sup = cfg[0] ? 3'h7 : 3'h7 >> (2'h3 - cfg[4:3]);
        sel = (cfg[6:5] != 2'h0) && !cfg[2] && sup[cfg[6:5] - 2'h1];
        pio = cfg[0] ? 2'h3 : cfg[8:7];
        dmin = sup[1] ? mx(dt[15:0], sup[2] ? D2 : D1) : 16'h0000;
        drec = sup[1] ? mx(dt[31:16], dmin) : 16'h0000;
        pfc = pio[0] ? ((pt[31:16] > PIO3_MAX_NS) ? PIO3_MAX_NS
                                                  : pt[31:16]) : 16'h0000;
        pnf = pio[0] ? mx(pt[15:0], pfc) : 16'h0000;
        if (cfg[0])
        begin
            {dmin, drec, pfc, pnf} = {4{SERIAL_CYCLE_NS}};
        end
        idx = 5'(w - WORD_FIRST);
        if (w < WORD_FIRST || w >= WORD_FIRST + WORD_CNT)
        begin
            return 16'h0000;
        end
        case (idx)
            I_VALID: return {14'h0000, (pio != 2'h0) | sup[1], 1'b0};
            I_DMA: return {5'h00, sel ? 3'h1 << (cfg[6:5] - 2'h1) : 3'h0,
                           5'h00, sup};
            I_PIO: return {14'h0000, pio};
            I_DMIN: return dmin;
            I_DREC: return drec;
            I_PNF: return pnf;
            I_PFC: return pfc;
            I_QD: return cfg[1] ? {11'h000, qd} : 16'h0000;
            I_VER: return {9'h000, cfg[12:9], 3'h0};
            default: return 16'h0000;
        endcase
    endfunction : expWord

    // ==========================================================
    // Comparison, bus and sequence tasks.
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // The answer is taken at the edge that samples pready high.
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            chk(32'h0, 32'h1);
            tally_and_finish();
        end
    endtask : apb

    task automatic wrChk(input logic [11:0] a, input logic [31:0] d,
                         input logic [31:0] rb);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        apb(1'b0, a, 32'h0, r, e);
        chk({e, r}, {1'b0, rb});
    endtask : wrChk

    task automatic cmds(input logic a, input logic k, input int n,
                        input logic [5:0] o, input logic f);
        @(posedge clk);
        cmdAccepted <= a;
        cmdCompleted <= k;
        repeat (n) @(posedge clk);
        cmdAccepted <= 1'b0;
        cmdCompleted <= 1'b0;
        @(negedge clk);
        chk({outstanding, queueFull}, {o, f});
    endtask : cmds

    task automatic tally_and_finish();
        if (errors == 0 && comparisons > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // Main sequence: reset, corner and random configurations, queue.
    initial
    begin
        logic [12:0] corner [6];
        logic [31:0] r;
        logic [15:0] d, ex, rc, h;
        logic e, ok;
        corner = '{13'h0001, 13'h0068, 13'h007C, 13'h1E7A, 13'h0190,
                   13'h0130};
        {reset_n, psel, penable, pwrite, cmdAccepted, cmdCompleted} = '0;
        {paddr, pwdata, hostCycleNs} = '0;
        {cfg, dt, pt, qd} = '0;
        void'($urandom(4035));
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        for (int a = 0; a <= 16; a += 4)
        begin
            apb(1'b0, 12'(a), 32'h0, r, e);
            chk({e, r}, 33'h0);
        end
        apb(1'b0, 12'h014, 32'h0, r, e);
        chk({e, r}, {1'b1, 32'h0});
        wrChk(WIN_BASE + 12'h028, 32'hFFFF_FFFF, 32'h0);
        for (int i = 0; i < 30; i++)
        begin
            r = $urandom;
            cfg = (i < 6) ? corner[i] : r[12:0];
            dt = {16'($urandom_range(600)), 16'($urandom_range(600))};
            pt = {16'($urandom_range(300)), 16'($urandom_range(300))};
            qd = 5'($urandom_range(31));
            wrChk(CTRL_OFF, r & 32'hFFFF_E000 | 32'(cfg), 32'(cfg));
            wrChk(DMA_TIME_OFF, dt, dt);
            wrChk(PIO_TIME_OFF, pt, pt);
            wrChk(QUEUE_OFF, {27'h0, qd} | 32'hFFFF_FF00, {27'h0, qd});
            for (int w = 52; w <= 81; w++)
            begin
                host_reader_inst.fetch(8'(w), d, ok);
                ex = expWord(8'(w));
                chk({ok, d}, {1'b1, ex});
            end
            ex = expWord(8'h3F);
            apb(1'b0, STATUS_OFF, 32'h0, r, e);
            d = expWord(8'h35);
            chk(r, {30'h0, ex[10:8] != 3'h0, d[1]});
            rc = expWord(8'h42);
            for (int k = 0; k < 2; k++)
            begin
                h = (k == 0) ? rc - 16'h0001 : rc;
                @(posedge clk);
                hostCycleNs <= h;
                repeat (2) @(posedge clk);
                @(negedge clk);
                chk(32'(dmaThrottle),
                    32'((ex[10:8] != 3'h0) && h != 16'h0 && h < rc));
            end
        end
        cfg = 13'h0002;
        qd = 5'h02;
        wrChk(CTRL_OFF, 32'(cfg), 32'(cfg));
        wrChk(QUEUE_OFF, 32'(qd), 32'(qd));
        cmds(1'b1, 1'b0, 5, 6'h03, 1'b1);
        cmds(1'b0, 1'b1, 1, 6'h02, 1'b0);
        cmds(1'b1, 1'b1, 1, 6'h02, 1'b0);
        cmds(1'b0, 1'b1, 4, 6'h00, 1'b0);
        wrChk(CTRL_OFF, 32'h0, 32'h0);
        cmds(1'b1, 1'b0, 2, 6'h01, 1'b1);
        tally_and_finish();
    end

    // Cuts a hung run short, well beyond the length of the tests.
    initial
    begin
        #100000;
        errors++;
        tally_and_finish();
    end
endmodule : tb_ident_cap_words

// ===== shared/ident_cap_pkg.sv
// Constants, offsets and carrier types of the identify capability words.
package ident_cap_pkg;

    // ==========================================================
    // Register byte offsets on the bus.
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] DMA_TIME_OFF = 12'h004;
    localparam logic [11:0] PIO_TIME_OFF = 12'h008;
    localparam logic [11:0] QUEUE_OFF = 12'h00C;
    localparam logic [11:0] STATUS_OFF = 12'h010;
    localparam logic [11:0] WIN_BASE = 12'h100;

    // ==========================================================
    // Identify word numbering; the window starts at the validity word.
    localparam logic [7:0] WORD_FIRST = 8'h35;
    localparam logic [7:0] WORD_CNT = 8'h1C;
    localparam logic [4:0] I_VALID = 5'h00;
    localparam logic [4:0] I_DMA = 5'h0A;
    localparam logic [4:0] I_PIO = 5'h0B;
    localparam logic [4:0] I_DMIN = 5'h0C;
    localparam logic [4:0] I_DREC = 5'h0D;
    localparam logic [4:0] I_PNF = 5'h0E;
    localparam logic [4:0] I_PFC = 5'h0F;
    localparam logic [4:0] I_RSV_LO = 5'h10;
    localparam logic [4:0] I_RSV_HI = 5'h15;
    localparam logic [4:0] I_QD = 5'h16;
    localparam logic [4:0] I_VER = 5'h1B;

    // ==========================================================
    // Cycle times in nanoseconds.
    localparam logic [15:0] SERIAL_CYCLE_NS = 16'h0078;
    localparam logic [15:0] PIO3_MAX_NS = 16'h00B4;

    // ==========================================================
    // Control register layout, high bits first down to serialIf.
    typedef struct packed {
        logic [3:0] version;
        logic [1:0] pioSup;
        logic [1:0] dmaSel;
        logic [1:0] dmaLevel;
        logic ultraEn;
        logic queued;
        logic serialIf;
    } cfg_s;

    localparam int CFG_W = $bits(cfg_s);

    // A pair of 16-bit cycle times sharing one register.
    typedef struct packed {
        logic [15:0] hi;
        logic [15:0] lo;
    } pair_s;

    // ==========================================================
    // Reset values.
    localparam cfg_s CTRL_RST = '0;
    localparam pair_s TIME_RST = '0;
    localparam logic [4:0] QUEUE_RST = 5'h00;

endpackage : ident_cap_pkg

// ===== src/ident_cap_words.sv
// Identify capability words 53 to 80 with an APB configuration slave.
//
// What this block does
// (RULE_01) Report at most one selected DMA mode; none while Ultra DMA is on.
// (RULE_02) Mode word bits 15 to 11 always read zero.
// (RULE_03) Bits 10, 9, 8 flag selected modes 2, 1, 0, one-hot or zero.
// (RULE_04) Mode word bits 7 to 3 always read zero.
// (RULE_05) Mode 2 support bit forces support bits 1 and 0.
// (RULE_06) Mode 1 support bit forces support bit 0.
// (RULE_07) Bit 0 flags mode 0; serial interface sets all three support bits.
// (RULE_08) PIO word bits 7 to 2 reserved, bit 0 mode 3, bit 1 mode 4.
// (RULE_09) PIO mode 3 bit is software set; serial forces both bits.
// (RULE_10) Any supported PIO or cycle field sets validity bit 1.
// (RULE_11) DMA minimum cycle needs mode 1, never below fastest mode's cycle.
// (RULE_12) DMA recommended cycle needs mode 1, never below the minimum word.
// (RULE_13) Throttle DMA when the host cycles faster than recommended.
// (RULE_14) Unsupported cycle-time fields read zero.
// (RULE_15) PIO cycle without flow control never below the flow-control one.
// (RULE_16) PIO flow-control cycle capped at 180 ns when mode 3 is claimed.
// (RULE_17) Serial interface forces all four cycle words to 120 ns.
// (RULE_18) Queue word bits 4 to 0 hold maximum depth minus one.
// (RULE_19) Count accepted, not yet completed commands against the depth.
// (RULE_20) Without queued command support the depth field is zero.
// (RULE_21) Version word only carries bits 6 to 3, several may be set.
// (RULE_22) Words 69 to 74 read as zero.
// (RULE_23) Validity bit 1 marks words 64 to 70 as valid.
// (RULE_24) Every reserved bit and word in the range reads zero.
//
// The APB slave port and the register offsets were chosen for this implementation.
module ident_cap_words
    import ident_cap_pkg::*;
#(
    parameter logic [15:0] DMA0_NS = 16'h01E0,
    parameter logic [15:0] DMA1_NS = 16'h0096,
    parameter logic [15:0] DMA2_NS = 16'h0078
)(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wordReq,
    input wire logic [7:0] wordIdx,
    output logic [15:0] wordData,
    output logic wordValid,
    input wire logic [15:0] hostCycleNs,
    input wire logic cmdAccepted,
    input wire logic cmdCompleted,
    output logic dmaThrottle,
    output logic [5:0] outstanding,
    output logic queueFull
);

    // ==========================================================
    // Software registers and the last word port request.
    cfg_s ctrl_reg;
    pair_s dmaTime_reg;
    pair_s pioTime_reg;
    logic [4:0] queue_reg;
    logic [4:0] lastRel_reg;
    logic lastHit_reg;

    function automatic logic [15:0] maxw(input logic [15:0] a,
                                         input logic [15:0] b);
        return (a > b) ? a : b;
    endfunction : maxw

    function automatic logic [15:0] minw(input logic [15:0] a,
                                         input logic [15:0] b);
        return (a < b) ? a : b;
    endfunction : minw

    // ==========================================================
    // Mode support and selection.
    wire logic serialIf = ctrl_reg.serialIf;
    wire logic [1:0] lvl = serialIf ? 2'h3 : ctrl_reg.dmaLevel; // [RULE_07]
    // Support is thermometer coded so a faster mode implies the slower.
    wire logic [2:0] dmaSup = {lvl == 2'h3, lvl >= 2'h2, lvl >= 2'h1}; // [RULE_05] [RULE_06]
    wire logic [1:0] selMode = ctrl_reg.dmaSel;
    wire logic [1:0] selBit = 2'(selMode - 2'h1);
    // A selection of an unsupported mode, or while Ultra DMA runs, is dropped.
    wire logic selOk = (selMode != 2'h0) && !ctrl_reg.ultraEn
                       && dmaSup[selBit]; // [RULE_01]
    logic [2:0] selHot;

    // One selection flag per block-transfer mode.
    genvar m;
    for (m = 0; m < 3; m++)
    begin : gSel
        assign selHot[m] = selOk && (selMode == 2'(m + 1)); // [RULE_03]
    end

    // Reserved bits are forced to zero around the two fields.
    wire logic [15:0] dmaWord = {5'h00, selHot, 5'h00, dmaSup}; // [RULE_02] [RULE_04]
    wire logic [1:0] pioSup = serialIf ? 2'h3 : ctrl_reg.pioSup; // [RULE_09]
    wire logic [15:0] pioWord = {14'h0000, pioSup}; // [RULE_08]

    // ==========================================================
    // Cycle-time words, clamped so the reported set stays consistent.
    wire logic [15:0] fastestDma = dmaSup[2] ? DMA2_NS
                                 : (dmaSup[1] ? DMA1_NS : DMA0_NS);
    wire logic dmaTimeOn = dmaSup[1];
    wire logic pioOn = pioSup[0];
    wire logic [15:0] dminCfg = maxw(dmaTime_reg.lo, fastestDma); // [RULE_11]
    wire logic [15:0] dmin = serialIf ? SERIAL_CYCLE_NS
                           : (dmaTimeOn ? dminCfg : 16'h0000); // [RULE_14] [RULE_17]
    wire logic [15:0] drec = serialIf ? SERIAL_CYCLE_NS
                           : (dmaTimeOn ? maxw(dmaTime_reg.hi, dmin)
                           : 16'h0000); // [RULE_12]
    wire logic [15:0] pfc = serialIf ? SERIAL_CYCLE_NS
                          : (pioOn ? minw(pioTime_reg.hi, PIO3_MAX_NS)
                          : 16'h0000); // [RULE_16]
    wire logic [15:0] pnf = serialIf ? SERIAL_CYCLE_NS
                          : (pioOn ? maxw(pioTime_reg.lo, pfc)
                          : 16'h0000); // [RULE_15]

    // Validity bit 1 covers words 64 to 70.
    wire logic fieldValid = (|pioSup) || (|dmin) || (|drec)
                            || (|pnf) || (|pfc); // [RULE_10] [RULE_23]
    wire logic [4:0] qd = ctrl_reg.queued ? queue_reg : 5'h00; // [RULE_18] [RULE_20]
    wire logic [15:0] verWord = {9'h000, ctrl_reg.version, 3'h0}; // [RULE_21]

    // ==========================================================
    // Word image; anything not named below stays zero.
    logic [15:0] idw [0:31];

    always_comb
    begin
        for (int i = 0; i < 32; i++)
        begin
            idw[i] = 16'h0000; // [RULE_22] [RULE_24]
        end
        idw[I_VALID] = {14'h0000, fieldValid, 1'b0};
        idw[I_DMA] = dmaWord;
        idw[I_PIO] = pioWord;
        idw[I_DMIN] = dmin;
        idw[I_DREC] = drec;
        idw[I_PNF] = pnf;
        idw[I_PFC] = pfc;
        idw[I_QD] = {11'h000, qd};
        idw[I_VER] = verWord;
    end

    // Word port decode.
    wire logic [7:0] wRel = 8'(wordIdx - WORD_FIRST);
    wire logic wHit = (wordIdx >= WORD_FIRST) && (wRel < WORD_CNT);

    // ==========================================================
    // Queue accounting.
    wire logic [5:0] qLimit = 6'({1'b0, qd} + 6'h01);
    wire logic accOk = cmdAccepted && (outstanding < qLimit);
    wire logic compOk = cmdCompleted && (outstanding != 6'h00);
    wire logic [5:0] outNext = 6'(outstanding + {5'h00, accOk}
                                  - {5'h00, compOk}); // [RULE_19]

    // ==========================================================
    // APB decode and read selection.
    wire logic [11:0] winOff = 12'(paddr - WIN_BASE);
    wire logic winHit = (paddr >= WIN_BASE) && (winOff[1:0] == 2'h0)
                        && ({2'h0, winOff[11:2]} < {4'h0, WORD_CNT});
    wire logic hitCtrl = paddr == CTRL_OFF;
    wire logic hitDma = paddr == DMA_TIME_OFF;
    wire logic hitPio = paddr == PIO_TIME_OFF;
    wire logic hitQueue = paddr == QUEUE_OFF;
    wire logic hitStatus = paddr == STATUS_OFF;
    wire logic writable = hitCtrl || hitDma || hitPio || hitQueue;
    wire logic mapped = writable || hitStatus || winHit;
    wire logic [31:0] statusWord = 32'({outstanding, 5'h00, queueFull,
                                        selOk, fieldValid});
    wire logic [31:0] rdMux = winHit ? {16'h0000, idw[winOff[6:2]]}
                            : hitCtrl ? 32'(ctrl_reg)
                            : hitDma ? dmaTime_reg
                            : hitPio ? pioTime_reg
                            : hitQueue ? {27'h0000000, queue_reg}
                            : hitStatus ? statusWord : 32'h00000000;
    wire logic access = psel && penable && !pready;
    wire logic wrEn = psel && penable && pready && pwrite && writable;

    // Bus handshake: one wait state, then a single-cycle pready.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= access;
            pslverr <= access && !mapped;
            prdata <= (access && !pwrite) ? rdMux : 32'h00000000;
        end
    end

    // Register writes commit on the completing edge of the transfer.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_reg <= CTRL_RST;
            dmaTime_reg <= TIME_RST;
            pioTime_reg <= TIME_RST;
            queue_reg <= QUEUE_RST;
        end
        else if (wrEn)
        begin
            if (hitCtrl)
                ctrl_reg <= cfg_s'(pwdata[CFG_W-1:0]);
            if (hitDma)
                dmaTime_reg <= pwdata;
            if (hitPio)
                pioTime_reg <= pwdata;
            if (hitQueue)
                queue_reg <= pwdata[4:0];
        end
    end

    // Word port answers one cycle after a request.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wordData <= 16'h0000;
            wordValid <= 1'b0;
            lastRel_reg <= 5'h00;
            lastHit_reg <= 1'b0;
        end
        else
        begin
            wordValid <= wordReq;
            if (wordReq)
            begin
                wordData <= wHit ? idw[wRel[4:0]] : 16'h0000;
                lastRel_reg <= wRel[4:0];
                lastHit_reg <= wHit;
            end
        end
    end

    // Flow control toward the DMA transport and queue counters.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dmaThrottle <= 1'b0;
            outstanding <= 6'h00;
            queueFull <= 1'b0;
        end
        else
        begin
            dmaThrottle <= selOk && (hostCycleNs != 16'h0000)
                           && (hostCycleNs < drec); // [RULE_13]
            outstanding <= outNext;
            queueFull <= outNext >= qLimit;
        end
    end

    // ==========================================================
    // Assertions.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    wire logic rdDma = wordValid && lastHit_reg && lastRel_reg == I_DMA;
    wire logic rdPio = wordValid && lastHit_reg && lastRel_reg == I_PIO;
    wire logic rdRsv = wordValid && lastHit_reg
                       && lastRel_reg >= I_RSV_LO && lastRel_reg <= I_RSV_HI;

    dmaSelOne_a: assert property ( // [RULE_01]
        rdDma |-> $onehot0(wordData[10:8])
                  && !($past(ctrl_reg.ultraEn) && |wordData[10:8]))
        else $error("more than one DMA mode selected");
    dmaHighRsv_a: assert property ( // [RULE_02]
        rdDma |-> wordData[15:11] == 5'h00)
        else $error("mode word high reserved bits set");
    dmaSelMode_a: assert property ( // [RULE_03]
        rdDma && $past(selOk) |-> wordData[8 + $past(selBit)])
        else $error("selected mode flag missing");
    dmaLowRsv_a: assert property ( // [RULE_04]
        rdDma |-> wordData[7:3] == 5'h00)
        else $error("mode word low reserved bits set");
    dmaThermo_a: assert property ( // [RULE_05]
        rdDma && wordData[2] |-> wordData[1:0] == 2'h3)
        else $error("mode 2 without modes 1 and 0");
    dmaMode1_a: assert property ( // [RULE_06]
        rdDma && wordData[1] |-> wordData[0])
        else $error("mode 1 without mode 0");
    serialDma_a: assert property ( // [RULE_07]
        serialIf |-> dmaSup == 3'h7)
        else $error("serial device lacks DMA support bits");
    pioRsv_a: assert property ( // [RULE_08]
        rdPio |-> wordData[15:2] == 14'h0000)
        else $error("PIO reserved bits set");
    serialPio_a: assert property ( // [RULE_09]
        rdPio && $past(serialIf) |-> wordData[1:0] == 2'h3)
        else $error("serial device lacks PIO bits");
    validBit_a: assert property ( // [RULE_10]
        wordReq && wHit && wRel[4:0] == I_VALID && (|pioSup || |dmin)
        |=> wordValid && wordData[1])
        else $error("validity bit not set");
    dminFloor_a: assert property ( // [RULE_11]
        dmin != 16'h0000 |-> dmin >= fastestDma)
        else $error("DMA minimum below fastest mode");
    drecFloor_a: assert property ( // [RULE_12]
        drec >= dmin)
        else $error("DMA recommended below minimum");
    throttle_a: assert property ( // [RULE_13]
        dmaThrottle |-> $past(hostCycleNs) < $past(drec))
        else $error("throttle without fast host");
    unsupZero_a: assert property ( // [RULE_14]
        !dmaSup[1] |-> dmin == 16'h0000 && drec == 16'h0000)
        else $error("unsupported DMA time not zero");
    pnfFloor_a: assert property ( // [RULE_15]
        pnf >= pfc)
        else $error("PIO cycle below flow-control cycle");
    pfcCap_a: assert property ( // [RULE_16]
        pioOn |-> pfc <= PIO3_MAX_NS)
        else $error("flow-control cycle over limit");
    serialTime_a: assert property ( // [RULE_17]
        serialIf |-> dmin == SERIAL_CYCLE_NS && drec == SERIAL_CYCLE_NS
                     && pnf == SERIAL_CYCLE_NS && pfc == SERIAL_CYCLE_NS)
        else $error("serial cycle time not 120 ns");
    queueBound_a: assert property ( // [RULE_19]
        outstanding <= qLimit ##1 (queueFull == (outstanding >= qLimit)
                                   || $changed(qLimit)))
        else $error("outstanding beyond queue depth");
    queueZero_a: assert property ( // [RULE_20]
        !ctrl_reg.queued |-> qd == 5'h00 && qLimit == 6'h01)
        else $error("depth set without queuing");
    verRsv_a: assert property ( // [RULE_21]
        verWord[15:7] == 9'h000 && verWord[2:0] == 3'h0)
        else $error("version reserved bits set");
    rsvWord_a: assert property ( // [RULE_22]
        rdRsv |-> wordData == 16'h0000)
        else $error("reserved word not zero");

    mode2Sel_c: cover property (rdDma && wordData[10]);
    throttle_c: cover property (dmaThrottle);
    queueFull_c: cover property (queueFull ##1 !queueFull);
    serialRd_c: cover property (rdPio && wordData[1:0] == 2'h3);

endmodule : ident_cap_words
